// ==== dv/bgm_ext_io.sv ====
`timescale 1ns/1ns
`default_nettype none
module bgm_ext_io (
  input  wire logic [15:0] out_i,
  input  wire logic [15:0] oe_i,
  input  wire logic [15:0] pen_i,
  input  wire logic [15:0] pup_i,
  input  wire logic        adc_i,
  output logic      [15:0] pad_o
);
  // Pad level: drive, else pull, else flipped
  always_comb
  begin
    pad_o = (oe_i & out_i) | (~oe_i & pen_i & pup_i) | (~oe_i & ~pen_i & ~out_i);
    if (adc_i && !oe_i[11]) pad_o[11] = 1'b1; // Converter owns pin 11
  end
endmodule : bgm_ext_io
`default_nettype wire

// ==== dv/bgm_pin_mux_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module bgm_pin_mux_props
  import bgm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire bgm_pkg::bgm_wb_req_t wb_req_i,
  input wire logic wb_ack_o,
  input wire logic [15:0] pin_oe_o,
  input wire logic [15:0] pin_pull_en_o,
  input wire logic [15:0] pin_pull_up_o,
  input wire logic [19:0] mem_addr_i,
  input wire logic mem_req_i,
  input wire logic flash_sel_o,
  input wire logic socket_top_address_line_o,
  input wire logic socket_top_address_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Bus answer timing
  property p_ack; wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_cause; $rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb); endproperty
  a_cause: assert property (p_cause) else $error("ack unasked");
  // Pin state after reset
  property p_rst; $rose(rstn_i) |-> pin_pull_en_o == 16'hffff && pin_pull_up_o == 16'hff5f && pin_oe_o == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pins");
  property p_excl; (pin_oe_o & pin_pull_en_o) == 16'h0; endproperty
  a_excl: assert property (p_excl) else $error("pull on driven pin");
  // Flash window and bank line
  property p_win; flash_sel_o == (mem_req_i && mem_addr_i >= 20'h80000 && mem_addr_i <= 20'hbffff); endproperty
  a_win: assert property (p_win) else $error("flash decode");
  property p_bank; !socket_top_address_oe_o |-> socket_top_address_line_o; endproperty
  a_bank: assert property (p_bank) else $error("bank not up");
  property p_boe; $stable(socket_top_address_oe_o) || $past(wb_ack_o); endproperty
  a_boe: assert property (p_boe) else $error("bank oe moved");
  c_ack: cover property (wb_ack_o);
  c_win: cover property (flash_sel_o);
  c_low: cover property (socket_top_address_oe_o && !socket_top_address_line_o);
endmodule : bgm_pin_mux_props
`default_nettype wire

// ==== dv/test_board_gpio_pin_mux_bank_select.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_board_gpio_pin_mux_bank_select;
  import bgm_pkg::*;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, wb_ack_o, flash_sel_o, t_line, t_oe, mreq = 1'b0, adc = 1'b0;
  bgm_wb_req_t req = '0;
  logic [31:0] rdat, rq;
  logic [15:0] pad, pout, poe, pen, pup, ain;
  logic [19:0] madr = '0;
  int num_errors = 0, cmp_count = 0;
  int map [16] = '{30, 12, 13, 20, 11, 10, 0, 1, 31, 16, 17, 18, 19, 27, 28, 21};
  logic [19:0] fa [4] = '{20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000};
  bgm_pin_mux i_dut (.ref_clk_i, .rstn_i, .wb_req_i(req), .wb_dat_o(rdat), .wb_ack_o, .pin_in_i(pad),
    .pin_out_o(pout), .pin_oe_o(poe), .pin_pull_en_o(pen), .pin_pull_up_o(pup), .alt_out_i(16'hffff),
    .alt_oe_i(16'hffff), .alt_in_o(ain), .mem_addr_i(madr), .mem_req_i(mreq), .flash_sel_o,
    .socket_top_address_line_o(t_line), .socket_top_address_oe_o(t_oe));
  bgm_ext_io i_ext (.out_i(pout), .oe_i(poe), .pen_i(pen), .pup_i(pup), .adc_i(adc), .pad_o(pad));
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // One classic cycle, released at the ack edge
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, 4'h3, a, d};
    do begin @(posedge ref_clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    rq = rdat;
    req <= '0;
    if (wb_ack_o !== 1'b1) begin num_errors++; complete_run(); end
    @(posedge ref_clk_i);
  endtask : acc
  // Test sequence
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    `CHK("pull_up", 16'hff5f, pup)
    `CHK("pull_en", 16'hffff, pen)
    `CHK("bank", 2'b10, {t_line, t_oe})
    $display("reset test done");
    acc(OFF_MODE_HI, 1'b1, 32'h0200);
    acc(OFF_DIR_HI, 1'b1, 32'hfdff);
    `CHK("bank out", 2'b11, {t_line, t_oe})
    acc(OFF_DATA_HI, 1'b1, 32'hfdff);
    `CHK("bank low", 2'b01, {t_line, t_oe})
    acc(OFF_DIR_HI, 1'b0, 32'h0);
    `CHK("dir", 32'hfdff, rq)
    $display("bank test done");
    acc(OFF_MODE_LO, 1'b1, 32'hffff);
    acc(OFF_MODE_HI, 1'b1, 32'hffff);
    acc(OFF_DIR_LO, 1'b1, 32'h0);
    acc(OFF_DIR_HI, 1'b1, 32'h0);
    for (int p = 0; p < 16; p++)
    begin
      logic [31:0] v;
      v = 32'h1 << map[p];
      acc(OFF_DATA_LO, 1'b1, {16'h0, v[15:0]});
      acc(OFF_DATA_HI, 1'b1, {16'h0, v[31:16]});
      `CHK("map", 16'h1 << p, pout & poe)
    end
    $display("map test done");
    acc(OFF_MODE_LO, 1'b1, 32'h0);
    acc(OFF_MODE_HI, 1'b1, 32'h0);
    acc(OFF_DIR_HI, 1'b1, 32'h0);
    `CHK("alt", 16'h17ff, poe & pout)
    acc(OFF_OPTION, 1'b1, 32'hf);
    adc <= 1'b1;
    `CHK("alt jmp", 16'hf7ff, poe & pout)
    acc(8'h40, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rq)
    `CHK("alt in", 16'hffff, ain)
    $display("alternate test done");
    foreach (fa[i])
    begin
      madr <= fa[i];
      mreq <= 1'b1;
      @(posedge ref_clk_i);
      `CHK("flash", (i == 1 || i == 2), flash_sel_o)
    end
    $display("flash test done");
    complete_run();
  end
endmodule : test_board_gpio_pin_mux_bank_select
bind bgm_pin_mux bgm_pin_mux_props i_props (.ref_clk_i, .rstn_i, .wb_req_i, .wb_ack_o, .pin_oe_o,
  .pin_pull_en_o, .pin_pull_up_o, .mem_addr_i, .mem_req_i, .flash_sel_o, .socket_top_address_line_o,
  .socket_top_address_oe_o);
`default_nettype wire

// ==== verilog/bgm_pin_mux.sv ====
// Summary of operation
// - Sixteen pins, four selectable functions each
// - Reset: inputs pulled up, pins 5,7 down
// - Pins map to fixed internal port bits
// - Pins 13-15 alternates need jumpers
// - Pin 11 carries end-of-conversion when fitted
// - Flash socket decoded at 80000h-BFFFFh
// - Port bit 25 drives socket top address
`timescale 1ns/1ns
`default_nettype none
module bgm_pin_mux
  import bgm_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    rstn_i,
  input  wire bgm_pkg::bgm_wb_req_t    wb_req_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [15:0]             pin_in_i,
  output logic [15:0]                  pin_out_o,
  output logic [15:0]                  pin_oe_o,
  output logic [15:0]                  pin_pull_en_o,
  output logic [15:0]                  pin_pull_up_o,
  input  wire logic [15:0]             alt_out_i,
  input  wire logic [15:0]             alt_oe_i,
  output logic [15:0]                  alt_in_o,
  input  wire logic [19:0]             mem_addr_i,
  input  wire logic                    mem_req_i,
  output logic                         flash_sel_o,
  output logic                         socket_top_address_line_o,
  output logic                         socket_top_address_oe_o
);
  import bgm_pkg::*;

  // Pin to port bit map
  localparam logic [4:0] PIN_MAP [16] = '{5'd30, 5'd12, 5'd13, 5'd20, 5'd11, 5'd10, 5'd0, 5'd1,
                                          5'd31, 5'd16, 5'd17, 5'd18, 5'd19, 5'd27, 5'd28, 5'd21};

  // Port configuration and bus state
  logic [31:0] mode_reg, mode_next;
  logic [31:0] dir_reg, dir_next;
  logic [31:0] data_reg, data_next;
  logic [3:0]  opt_reg, opt_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  // Pad path and bus decode helpers
  logic [15:0] sync1_reg, sync2_reg;
  logic [31:0] port_pins;
  logic [15:0] alt_allow;
  logic        req;
  logic        rd_take;
  logic        wr_take;
  logic        bank_out;
  logic [31:0] wmask;

  // Pad input synchroniser
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
    end
    else
    begin
      sync1_reg <= pin_in_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Alternate function gating by board options
  always_comb
  begin
    alt_allow     = 16'hffff;
    alt_allow[13] = opt_reg[OPT_TX_JMP_BIT];
    alt_allow[14] = opt_reg[OPT_RX_JMP_BIT];
    alt_allow[15] = opt_reg[OPT_CTS_JMP_BIT];
    alt_allow[11] = opt_reg[OPT_ADC_BIT];
  end

  // Pad drive per pin from mode/direction
  always_comb
  begin
    port_pins = 32'h0000_0000;
    for (int i = 0; i < 16; i++)
    begin
      bgm_fn_t  fn;
      bgm_pad_t pad;
      fn  = bgm_fn_t'({mode_reg[PIN_MAP[i]], dir_reg[PIN_MAP[i]]});
      pad = '{out: 1'b0, oe: 1'b0, pull_en: 1'b0, pull_up: 1'b0};
      case (fn)
        FN_PERIPH:
        begin
          // Alternate output only when allowed; EOC pin stays input
          pad.out = alt_out_i[i];
          pad.oe  = alt_oe_i[i] & alt_allow[i] & ~(i == 11);
        end
        FN_INPUT_NP: pad.oe = 1'b0;
        FN_OUTPUT:
        begin
          // Push-pull, or open-drain when data low only is driven via dir toggling
          pad.out = data_reg[PIN_MAP[i]];
          pad.oe  = 1'b1;
        end
        FN_INPUT_PUL:
        begin
          pad.pull_en = 1'b1;
          pad.pull_up = data_reg[PIN_MAP[i]];
        end
        default: pad.oe = 1'b0;
      endcase
      pin_out_o[i]     = pad.out;
      pin_oe_o[i]      = pad.oe;
      pin_pull_en_o[i] = pad.pull_en;
      pin_pull_up_o[i] = pad.pull_up;
      alt_in_o[i]      = sync2_reg[i] & alt_allow[i] & (fn == FN_PERIPH);
      port_pins[PIN_MAP[i]] = sync2_reg[i];
    end
  end

  // Bank select line; undriven, the pull-up keeps the upper half selected
  always_comb
  begin
    // Port bit 25 drives the socket only as an output (mode 1, dir 0)
    bank_out = mode_reg[BANK_SEL_BIT] & ~dir_reg[BANK_SEL_BIT];
    socket_top_address_oe_o = bank_out;
    socket_top_address_line_o = bank_out ? data_reg[BANK_SEL_BIT] : 1'b1;
    // Socket window decode
    flash_sel_o = mem_req_i && (mem_addr_i >= FLASH_BASE) && (mem_addr_i <= FLASH_LAST);
  end

  // Configuration write path; a write lands on the edge where ack is seen high
  always_comb
  begin
    wr_take   = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_reg;
    wmask     = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    mode_next = mode_reg;
    dir_next  = dir_reg;
    data_next = data_reg;
    opt_next  = opt_reg;
    if (wr_take)
    begin
      case (wb_req_i.adr)
        OFF_MODE_LO: mode_next[15:0]  = (mode_reg[15:0] & ~wmask[15:0]) | (wb_req_i.dat[15:0] & wmask[15:0]);
        OFF_DIR_LO:  dir_next[15:0]   = (dir_reg[15:0] & ~wmask[15:0]) | (wb_req_i.dat[15:0] & wmask[15:0]);
        OFF_DATA_LO: data_next[15:0]  = (data_reg[15:0] & ~wmask[15:0]) | (wb_req_i.dat[15:0] & wmask[15:0]);
        OFF_MODE_HI: mode_next[31:16] = (mode_reg[31:16] & ~wmask[15:0]) | (wb_req_i.dat[15:0] & wmask[15:0]);
        OFF_DIR_HI:  dir_next[31:16]  = (dir_reg[31:16] & ~wmask[15:0]) | (wb_req_i.dat[15:0] & wmask[15:0]);
        OFF_DATA_HI: data_next[31:16] = (data_reg[31:16] & ~wmask[15:0]) | (wb_req_i.dat[15:0] & wmask[15:0]);
        OFF_OPTION:
        begin
          // Option bits sit in byte lane 0 only
          if (wb_req_i.sel[0])
          begin
            opt_next = wb_req_i.dat[3:0];
          end
        end
        default:     ;
      endcase
    end
  end

  // Configuration registers; reset leaves every pin a pulled input
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      mode_reg <= RST_MODE;
      dir_reg  <= RST_DIR;
      data_reg <= RST_DATA;
      opt_reg  <= RST_OPT;
    end
    else
    begin
      mode_reg <= mode_next;
      dir_reg  <= dir_next;
      data_reg <= data_next;
      opt_reg  <= opt_next;
    end
  end

  // Bus answer; a request is taken while ack is low, answered one cycle later
  always_comb
  begin
    req       = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
    rd_take   = req & ~wb_req_i.we;
    ack_next  = req;
    rdat_next = rdat_reg;
    if (rd_take)
    begin
      case (wb_req_i.adr)
        OFF_MODE_LO: rdat_next = {16'h0000, mode_reg[15:0]};
        OFF_DIR_LO:  rdat_next = {16'h0000, dir_reg[15:0]};
        OFF_DATA_LO: rdat_next = {16'h0000, data_reg[15:0]};
        OFF_MODE_HI: rdat_next = {16'h0000, mode_reg[31:16]};
        OFF_DIR_HI:  rdat_next = {16'h0000, dir_reg[31:16]};
        OFF_DATA_HI: rdat_next = {16'h0000, data_reg[31:16]};
        OFF_PINS_LO: rdat_next = {16'h0000, port_pins[15:0]};
        OFF_PINS_HI: rdat_next = {16'h0000, port_pins[31:16]};
        OFF_OPTION:  rdat_next = {28'h0000000, opt_reg};
        default:     rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // Bus outputs straight from flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
endmodule : bgm_pin_mux
`default_nettype wire

// ==== verilog/bgm_pkg.sv ====
`default_nettype none
package bgm_pkg;
  // Pin count and internal port width
  localparam int unsigned PIN_COUNT  = 16;
  localparam int unsigned PORT_WIDTH = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE_LO = 8'h00;
  localparam logic [7:0] OFF_DIR_LO  = 8'h04;
  localparam logic [7:0] OFF_DATA_LO = 8'h08;
  localparam logic [7:0] OFF_MODE_HI = 8'h0c;
  localparam logic [7:0] OFF_DIR_HI  = 8'h10;
  localparam logic [7:0] OFF_DATA_HI = 8'h14;
  localparam logic [7:0] OFF_PINS_LO = 8'h18;
  localparam logic [7:0] OFF_PINS_HI = 8'h1c;
  localparam logic [7:0] OFF_OPTION  = 8'h20;

  // Option register field positions
  localparam int unsigned OPT_TX_JMP_BIT  = 0;
  localparam int unsigned OPT_RX_JMP_BIT  = 1;
  localparam int unsigned OPT_CTS_JMP_BIT = 2;
  localparam int unsigned OPT_ADC_BIT     = 3;

  // Port bit carrying the flash bank select
  localparam int unsigned BANK_SEL_BIT = 25;

  // Reset values (mode=0,dir=1: input with pull; pull level from data)
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_DIR  = 32'hffff_ffff;
  localparam logic [31:0] RST_DATA = 32'hffff_fbfd;
  localparam logic [3:0]  RST_OPT  = 4'h0;

  // Flash socket window
  localparam logic [19:0] FLASH_BASE = 20'h80000;
  localparam logic [19:0] FLASH_LAST = 20'hbffff;

  // Pin function encoding from mode and direction bits
  typedef enum logic [1:0] {
    FN_PERIPH    = 2'b00,
    FN_INPUT_PUL = 2'b01,
    FN_OUTPUT    = 2'b10,
    FN_INPUT_NP  = 2'b11
  } bgm_fn_t;

  // Per-pin drive to pad
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_en;
    logic pull_up;
  } bgm_pad_t;

  // Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } bgm_wb_req_t;
endpackage : bgm_pkg
`default_nettype wire
